// ===== verilog/tsp_regs.vh
// Constants for the thermometer serial and pulse output block
`ifndef TSP_REGS_VH
`define TSP_REGS_VH
`define TSP_CLK_HZ          100000000
`define TSP_FALL_DELAY_NS   300
`define TSP_FALL_DELAY_CYC  ((`TSP_FALL_DELAY_NS * (`TSP_CLK_HZ / 1000000) + 999) / 1000)
`define TSP_TIMEOUT_L_US    30000
`define TSP_TIMEOUT_H_US    45
`define TSP_REQ_US          2000
`define TSP_WAKE_MS         80
`define TSP_FIRST_RES_MS    200
`define TSP_US_CYC          (`TSP_CLK_HZ / 1000000)
`define TSP_CMD_RAM         3'h0
`define TSP_CMD_EEPROM      3'h1
`define TSP_CMD_FLAGS       8'hF0
`define TSP_CMD_SLEEP       8'hFF
`define TSP_FLAG_BUSY_BIT   7
`define TSP_FLAG_DEAD_BIT   5
`define TSP_FLAG_INIT_BIT   4
`define TSP_SRC_TA_OBJ1     2'h0
`define TSP_SRC_TA_OBJ2     2'h1
`define TSP_SRC_OBJ2        2'h2
`define TSP_SRC_OBJ1_OBJ2   2'h3
`define TSP_REG_CTRL        4'h0
`define TSP_REG_STATUS      4'h1
`define TSP_REG_TEMP_A      4'h2
`define TSP_REG_TEMP_1      4'h3
`define TSP_REG_TEMP_2      4'h4
`define TSP_REG_ADDR        4'h5
`define TSP_REG_LASTWR      4'h6
`define TSP_REG_PERIOD      4'h7
`define TSP_CTRL_RESET      32'h0000_0000
`define TSP_PERIOD_RESET    32'h0000_2000
`endif

// ===== verilog/tsp_top.v
// Thermometer serial slave and pulse output with Avalon-MM register access
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.vh"
module tsp_top #(
   parameter TIMEOUT_L_CYC = `TSP_TIMEOUT_L_US * `TSP_US_CYC,
   parameter TIMEOUT_H_CYC = `TSP_TIMEOUT_H_US * `TSP_US_CYC,
   parameter REQ_CYC       = `TSP_REQ_US * `TSP_US_CYC,
   parameter WAKE_CYC      = `TSP_WAKE_MS * 1000 * `TSP_US_CYC,
   parameter FIRST_RES_CYC = `TSP_FIRST_RES_MS * 1000 * `TSP_US_CYC
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        reset,
   // Avalon-MM slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // Serial pins
   input  wire        scl_in,
   input  wire        sda_in,
   output wire        sda_out,
   output wire        sda_oe,
   // Status
   output wire        pulse_mode,
   output wire        asleep,
   output wire        first_result_ready
);
// ----------------------------------------------------------------
// Constants and functions
// ----------------------------------------------------------------
localparam [31:0] FD_CYC = `TSP_FALL_DELAY_CYC;
localparam [31:0] TL = TIMEOUT_L_CYC;
localparam [31:0] TH = TIMEOUT_H_CYC;
localparam [31:0] TQ = REQ_CYC;
localparam [31:0] TW = WAKE_CYC;
localparam [31:0] TF = FIRST_RES_CYC;
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_RX   = 3'h1;
localparam [2:0] S_TX   = 3'h2;
localparam [2:0] S_WAIT = 3'h3;
function [7:0] crc8;
   input [7:0] c;
   input       b;
   reg         f;
   begin
      f = c[7] ^ b;
      crc8 = {c[6:0], 1'b0} ^ (f ? 8'h07 : 8'h00);
   end
endfunction
// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg  [31:0] ctrl_reg;      // [0] pulse en,[1] push-pull,[3:2] src,[4] busy,[5] dead,[6] init done
reg  [15:0] temp_a_reg, temp_1_reg, temp_2_reg;
reg  [6:0]  addr_reg;
reg  [31:0] lastwr_reg;
reg  [31:0] period_reg;
reg         rd_done_reg;
assign avs_waitrequest = (avs_read | avs_write) & ~rd_done_reg;
// ----------------------------------------------------------------
// Synchronisers and edges
// ----------------------------------------------------------------
reg  [1:0] scl_s, sda_s;
reg        scl_d, sda_d;
always @(posedge ref_clk) begin
   if (reset) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
   end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
   end
end
wire scl = scl_s[1];
wire sda = sda_s[1];
wire scl_rise = scl & ~scl_d;
wire scl_fall = ~scl & scl_d;
wire start_c = scl & scl_d & sda_d & ~sda;
wire stop_c  = scl & scl_d & ~sda_d & sda;
// ----------------------------------------------------------------
// Serial engine
// ----------------------------------------------------------------
reg  [2:0]  st_reg;
reg  [3:0]  bit_reg;
reg  [7:0]  sh_reg;
reg  [7:0]  crc_reg;
reg  [2:0]  byte_reg;
reg  [7:0]  cmd_reg;
reg         rd_reg;
reg  [15:0] wdat_reg;
reg  [23:0] tx_reg;
reg         drive_low_reg;
reg         ack_pend_reg, rel_pend_reg, nack_reg;
reg  [31:0] dly_reg, tmo_reg;
reg         pulse_mode_reg, sleep_reg;
reg  [31:0] wake_reg, first_reg;
reg         first_ready_reg;
wire [4:0]  widx = cmd_reg[4:0];
reg  [15:0] word_val;
always @* begin
   word_val = 16'h0000;
   if (cmd_reg == `TSP_CMD_FLAGS) begin
      word_val[`TSP_FLAG_BUSY_BIT] = ctrl_reg[4];
      word_val[`TSP_FLAG_DEAD_BIT] = ctrl_reg[5];
      word_val[`TSP_FLAG_INIT_BIT] = ctrl_reg[6];
   end else if (cmd_reg[7:5] == `TSP_CMD_RAM) begin
      case (widx)
         5'h06:   word_val = {1'b0, temp_a_reg[15:1]};
         5'h07:   word_val = {1'b0, temp_1_reg[15:1]};
         5'h08:   word_val = {1'b0, temp_2_reg[15:1]};
         default: word_val = 16'h0000;
      endcase
   end else if (cmd_reg[7:5] == `TSP_CMD_EEPROM) begin
      word_val = (widx == lastwr_reg[20:16]) ? lastwr_reg[15:0] : 16'h0000;
   end
end
wire addr_hit = (sh_reg[7:1] == addr_reg) || (sh_reg == 8'h00);
wire cmd_ok = (sh_reg[7:6] == 2'h0) || (sh_reg == `TSP_CMD_FLAGS) || (sh_reg == `TSP_CMD_SLEEP);
wire active = (st_reg != S_IDLE);
always @(posedge ref_clk) begin
   if (reset) begin
      st_reg <= S_IDLE; bit_reg <= 4'h0; sh_reg <= 8'h00; crc_reg <= 8'h00;
      byte_reg <= 3'h0; cmd_reg <= 8'h00; rd_reg <= 1'b0; wdat_reg <= 16'h0000;
      tx_reg <= 24'h000000; drive_low_reg <= 1'b0; ack_pend_reg <= 1'b0;
      rel_pend_reg <= 1'b0; nack_reg <= 1'b0; dly_reg <= 32'h0; tmo_reg <= 32'h0;
      pulse_mode_reg <= 1'b0; sleep_reg <= 1'b0; wake_reg <= 32'h0;
      first_reg <= 32'h0; first_ready_reg <= 1'b0; lastwr_reg <= 32'h0;
   end else begin
      // First result timer runs in either pin mode, held while asleep
      if (!sleep_reg && !first_ready_reg) begin
         first_reg <= first_reg + 32'h1;
         if (first_reg >= TF) first_ready_reg <= 1'b1;
      end
      // Pulse mode left only by a long low clock request
      if (pulse_mode_reg) begin
         tmo_reg <= scl ? 32'h0 : tmo_reg + 32'h1;
         if (!scl && tmo_reg >= TQ) begin
            pulse_mode_reg <= 1'b0;
            tmo_reg <= 32'h0;
         end
      end else if (sleep_reg) begin
         wake_reg <= (scl && !sda) ? wake_reg + 32'h1 : 32'h0;
         if (wake_reg >= TW) begin
            sleep_reg <= 1'b0;
            pulse_mode_reg <= ctrl_reg[0];
            first_reg <= 32'h0;
            first_ready_reg <= 1'b0;
         end
      end else begin
         // Timeouts count clock low anywhere, high only mid-transfer
         if (scl_rise || scl_fall || start_c) tmo_reg <= 32'h0;
         else if (!scl || active) tmo_reg <= tmo_reg + 32'h1;
         // Delayed drive changes, held off the falling edge
         if (ack_pend_reg || rel_pend_reg) begin
            dly_reg <= dly_reg + 32'h1;
            if (dly_reg + 32'h1 >= FD_CYC) begin
               if (ack_pend_reg) drive_low_reg <= ~nack_reg;
               else if (st_reg == S_TX) drive_low_reg <= ~tx_reg[23];
               else drive_low_reg <= 1'b0;
               ack_pend_reg <= 1'b0; rel_pend_reg <= 1'b0;
            end
         end
         if ((!scl && tmo_reg >= TL) || (scl && active && tmo_reg >= TH)) begin
            st_reg <= S_IDLE; drive_low_reg <= 1'b0;
            ack_pend_reg <= 1'b0; rel_pend_reg <= 1'b0; tmo_reg <= 32'h0;
         end else if (start_c) begin
            st_reg <= S_RX; bit_reg <= 4'h0;
            // A repeated start keeps the command and the running PEC for the read phase
            crc_reg <= (st_reg == S_RX) ? crc_reg : 8'h00;
            byte_reg <= (st_reg == S_RX) ? byte_reg : 3'h0;
            drive_low_reg <= 1'b0;
         end else if (stop_c) begin
            if (!rd_reg && byte_reg == 3'h5 && cmd_reg[7:5] == `TSP_CMD_EEPROM)
               lastwr_reg <= {11'h000, widx, wdat_reg};
            if (!rd_reg && byte_reg == 3'h2 && cmd_reg == `TSP_CMD_SLEEP)
               sleep_reg <= 1'b1;
            st_reg <= S_IDLE; drive_low_reg <= 1'b0; rd_reg <= 1'b0;
         end else if (scl_rise && (st_reg == S_RX || st_reg == S_WAIT)) begin
            if (bit_reg < 4'h8) begin
               sh_reg <= {sh_reg[6:0], sda};
               crc_reg <= crc8(crc_reg, sda);
            end
            bit_reg <= bit_reg + 4'h1;
         end else if (scl_rise && st_reg == S_TX) begin
            if (bit_reg == 4'h8) nack_reg <= sda;
            bit_reg <= bit_reg + 4'h1;
         end else if (scl_fall && st_reg == S_RX && bit_reg == 4'h8) begin
            // Eighth fall: decide acknowledge for the received byte
            nack_reg <= 1'b1;
            ack_pend_reg <= 1'b1; dly_reg <= 32'h0;
            if (byte_reg == 3'h0 || (byte_reg == 3'h2 && rd_reg)) begin
               if (addr_hit) begin
                  nack_reg <= 1'b0;
                  rd_reg <= sh_reg[0];
               end else st_reg <= S_WAIT;
            end else if (byte_reg == 3'h1) begin
               nack_reg <= ~cmd_ok;
               cmd_reg <= sh_reg;
            end else if (byte_reg == 3'h2 || byte_reg == 3'h3) begin
               nack_reg <= 1'b0;
               wdat_reg <= (byte_reg == 3'h2) ? {wdat_reg[15:8], sh_reg}
                                              : {sh_reg, wdat_reg[7:0]};
            end else if (byte_reg == 3'h4) begin
               nack_reg <= (crc_reg != 8'h00);
            end
         end else if (scl_fall && st_reg == S_RX && bit_reg == 4'h9) begin
            // Ninth fall: release ack, or start sending the word
            bit_reg <= 4'h0;
            byte_reg <= byte_reg + 3'h1;
            rel_pend_reg <= 1'b1; dly_reg <= 32'h0;
            if (nack_reg) st_reg <= S_WAIT;
            else if ((rd_reg && (byte_reg == 3'h0 || byte_reg == 3'h2)) ||
                     (byte_reg == 3'h1 && cmd_reg == `TSP_CMD_FLAGS)) begin
               st_reg <= S_TX;
               tx_reg <= {word_val[7:0], word_val[15:8], crc_reg};
               crc_reg <= crc_reg;
            end
         end else if (scl_fall && st_reg == S_TX) begin
            if (bit_reg == 4'h8) begin
               // Release goes through the delayed path so data never moves near the fall
               nack_reg <= 1'b1;
               ack_pend_reg <= 1'b1; dly_reg <= 32'h0;
            end else if (bit_reg == 4'h9) begin
               bit_reg <= 4'h0;
               if (nack_reg || byte_reg == 3'h7) st_reg <= S_WAIT;
               else begin
                  byte_reg <= byte_reg + 3'h1;
                  rel_pend_reg <= 1'b1; dly_reg <= 32'h0;
               end
            end else begin
               tx_reg <= {tx_reg[22:0], 1'b0};
               rel_pend_reg <= 1'b1; dly_reg <= 32'h0;
            end
         end
         // PEC of the read reply is built while the reply shifts out
         if (st_reg == S_TX && scl_rise && bit_reg < 4'h8 && byte_reg < 3'h5)
            crc_reg <= crc8(crc_reg, tx_reg[23]);
         if (st_reg == S_TX && scl_fall && bit_reg == 4'h9 && byte_reg == 3'h4)
            tx_reg <= {crc_reg, 16'h0000};
      end
   end
end
// ----------------------------------------------------------------
// Pulse generator
// ----------------------------------------------------------------
reg  [31:0] pcnt_reg;
reg  [9:0]  pcode_reg;
wire [15:0] psrc = (ctrl_reg[3:2] == `TSP_SRC_OBJ1_OBJ2) ? temp_1_reg :
                   (ctrl_reg[3:2] == `TSP_SRC_OBJ2)      ? temp_2_reg : temp_a_reg;
wire [31:0] t1   = {3'h0, period_reg[31:3]};
wire [41:0] prod = {11'h000, period_reg[31:1]} * {32'h0, pcode_reg};
wire [31:0] t2   = prod[41:10];
wire [31:0] hi_len = ctrl_reg[5] ? (period_reg - t1) : (t1 + t2);
always @(posedge ref_clk) begin
   if (reset) begin
      pcnt_reg <= 32'h0;
      pcode_reg <= 10'h000;
   end else if (pcnt_reg + 32'h1 >= period_reg) begin
      pcnt_reg <= 32'h0;
      pcode_reg <= psrc[15:6];
   end else begin
      pcnt_reg <= pcnt_reg + 32'h1;
   end
end
wire pulse_hi = pcnt_reg < hi_len;
assign sda_out = pulse_mode_reg ? pulse_hi : 1'b0;
assign sda_oe  = pulse_mode_reg ? (ctrl_reg[1] | ~pulse_hi) : drive_low_reg;
assign pulse_mode = pulse_mode_reg;
assign asleep = sleep_reg;
assign first_result_ready = first_ready_reg;
// ----------------------------------------------------------------
// Avalon-MM register access, one wait cycle per access
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
   if (reset) begin
      ctrl_reg <= `TSP_CTRL_RESET; period_reg <= `TSP_PERIOD_RESET;
      temp_a_reg <= 16'h0000; temp_1_reg <= 16'h0000; temp_2_reg <= 16'h0000;
      addr_reg <= 7'h5A; rd_done_reg <= 1'b0; avs_readdata <= 32'h0;
   end else begin
      rd_done_reg <= (avs_read | avs_write) & ~rd_done_reg;
      if (avs_write && rd_done_reg) begin
         case (avs_address)
            `TSP_REG_CTRL:   ctrl_reg <= avs_writedata;
            `TSP_REG_TEMP_A: temp_a_reg <= avs_writedata[15:0];
            `TSP_REG_TEMP_1: temp_1_reg <= avs_writedata[15:0];
            `TSP_REG_TEMP_2: temp_2_reg <= avs_writedata[15:0];
            `TSP_REG_ADDR:   addr_reg <= avs_writedata[6:0];
            `TSP_REG_PERIOD: period_reg <= avs_writedata;
            default: ;
         endcase
      end
      if (avs_read && !rd_done_reg) begin
         case (avs_address)
            `TSP_REG_CTRL:   avs_readdata <= ctrl_reg;
            `TSP_REG_STATUS: avs_readdata <= {25'h0, st_reg, first_ready_reg,
                                              sleep_reg, drive_low_reg, pulse_mode_reg};
            `TSP_REG_TEMP_A: avs_readdata <= {16'h0, temp_a_reg};
            `TSP_REG_TEMP_1: avs_readdata <= {16'h0, temp_1_reg};
            `TSP_REG_TEMP_2: avs_readdata <= {16'h0, temp_2_reg};
            `TSP_REG_ADDR:   avs_readdata <= {25'h0, addr_reg};
            `TSP_REG_LASTWR: avs_readdata <= lastwr_reg;
            `TSP_REG_PERIOD: avs_readdata <= period_reg;
            default:         avs_readdata <= 32'h0;
         endcase
      end
   end
end
endmodule
`default_nettype wire

// ===== test/tsp_top_monitor.sv
// Concurrent checks on the ports of the serial and pulse output block
`timescale 1ns/1ps
`default_nettype none
module tsp_top_monitor #(
   parameter TIMEOUT_H_CYC = 4500,
   parameter REQ_CYC       = 500,
   parameter WAKE_CYC      = 500,
   parameter FIRST_RES_CYC = 500
) (
   // Clock, reset and register bus
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Pins and status
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        pulse_mode,
   input wire logic        asleep,
   input wire logic        first_result_ready
);
   logic [15:0] lo_cnt, hi_cnt, wk_cnt, res_cnt;
   function automatic [15:0] sat(input [15:0] c);
      sat = (&c) ? c : c + 16'h1;
   endfunction
   // Raw pin counts and an awake-time count; the block sees the pins two flops later, hence the margins
   always @(posedge ref_clk) begin
      lo_cnt  <= scl_in ? 16'h0 : sat(lo_cnt);
      hi_cnt  <= scl_in ? sat(hi_cnt) : 16'h0;
      wk_cnt  <= (scl_in && !sda_in) ? sat(wk_cnt) : 16'h0;
      res_cnt <= (reset || asleep) ? 16'h0 : sat(res_cnt);
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence req_open;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence req_taken;
      !avs_waitrequest;
   endsequence
   a_wait_first: assert property ($rose(avs_read || avs_write) |-> req_open)
      else $error("no wait state on new request");
   a_wait_once: assert property (req_open |=> req_taken)
      else $error("wait state too long");
   a_idle_ready: assert property (!avs_read && !avs_write |-> req_taken)
      else $error("wait raised while idle");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[3] |->
      avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_status_bits: assert property (avs_read && !avs_waitrequest && avs_address == 4'h1 |->
      avs_readdata[3:2] == {$past(first_result_ready), $past(asleep)})
      else $error("status bits wrong");
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !sda_oe && !pulse_mode && !asleep)
      else $error("outputs active after reset");
   a_open_drain: assert property (sda_oe && !pulse_mode |-> !sda_out)
      else $error("data driven high in serial mode");
   a_change_low: assert property ($changed(sda_oe) && !pulse_mode && !$past(pulse_mode) &&
      !$past(pulse_mode, 2) && !$past(reset) |-> lo_cnt >= 16'd28 || hi_cnt >= TIMEOUT_H_CYC)
      else $error("data changed outside clock low window");
   a_wake_hold: assert property ($fell(asleep) && !$past(reset) |-> wk_cnt >= WAKE_CYC)
      else $error("woke too early");
   a_pulse_wake: assert property ($rose(pulse_mode) |-> $past(asleep) || $past(asleep, 2))
      else $error("pulse mode without wake");
   a_leave_pulse: assert property ($fell(pulse_mode) && !$past(reset) |-> lo_cnt >= REQ_CYC)
      else $error("pulse mode left too early");
   a_first_time: assert property ($rose(first_result_ready) |->
      res_cnt >= FIRST_RES_CYC / 2 && res_cnt <= 2 * FIRST_RES_CYC)
      else $error("first result out of time");
endmodule
bind tsp_top tsp_top_monitor #(.TIMEOUT_H_CYC(TIMEOUT_H_CYC), .REQ_CYC(REQ_CYC),
   .WAKE_CYC(WAKE_CYC), .FIRST_RES_CYC(FIRST_RES_CYC)) u_mon (.ref_clk(ref_clk),
   .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pulse_mode(pulse_mode),
   .asleep(asleep), .first_result_ready(first_result_ready));
`default_nettype wire

// ===== test/tsp_smb_master.sv
// Serial bus master model on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module tsp_smb_master (
   // Clock and wires
   input  wire logic ref_clk,
   input  wire logic sda,
   output var  logic scl = 1'b1,
   output var  logic sda_low = 1'b0
);
   localparam int HALF = 500; // 100 kHz bus clock
   logic [7:0] pec = 8'h00;
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      crc8 = c ^ d;
      repeat (8) crc8 = {crc8[6:0], 1'b0} ^ (crc8[7] ? 8'h07 : 8'h00);
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic start;
      pec = 8'h00;
      sda_low <= 1'b0;
      wt(40);
      scl <= 1'b1;
      wt(HALF);
      sda_low <= 1'b1;
      wt(HALF);
      scl <= 1'b0;
   endtask
   // Data moves only well after the falling clock edge
   task automatic tbit(input logic b, output logic r);
      wt(40);
      sda_low <= !b;
      wt(HALF - 40);
      scl <= 1'b1;
      wt(HALF / 2);
      r = sda;
      wt(HALF / 2);
      scl <= 1'b0;
   endtask
   // Bit in the ack slot is what the master drives; 1 leaves the line released
   task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q,
                        output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) tbit(d[i], q[i]);
      pec = crc8(pec, q);
      tbit(mack, a);
      ack = !a;
   endtask
   task automatic stop;
      wt(40);
      sda_low <= 1'b1;
      wt(HALF - 40);
      scl <= 1'b1;
      wt(HALF);
      sda_low <= 1'b0;
      wt(HALF);
   endtask
   task automatic hold_low(input int n);
      scl <= 1'b0;
      wt(n);
      scl <= 1'b1;
      wt(HALF);
   endtask
   task automatic wake(input int n);
      hold_low(HALF);
      sda_low <= 1'b1;
      wt(n);
      sda_low <= 1'b0;
      wt(HALF);
   endtask
endmodule
`default_nettype wire

// ===== test/tsp_top_test.sv
// Self-checking bench for the serial and pulse output block
`timescale 1ns/1ps
`default_nettype none
module tsp_top_test;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, sda_out, sda_oe, pulse_mode, asleep, first_ready, scl, sda_low;
   // Pulled-up wire: released by everyone it reads high
   wire         sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
   int          num_errors = 0;
   int          checked = 0;
   int          cycles = 0;
   int          n;
   logic [31:0] seed = 32'hCB0F7005;
   logic [31:0] q, r;
   logic [15:0] w;
   logic [7:0]  b;
   logic        a;
   localparam int LOW_CYC = 2000;
   localparam int SHORT_CYC = 500;
   always #5 ref_clk = !ref_clk;
   tsp_top #(.TIMEOUT_L_CYC(LOW_CYC), .REQ_CYC(SHORT_CYC), .WAKE_CYC(SHORT_CYC),
             .FIRST_RES_CYC(SHORT_CYC)) DUT (
      .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .pulse_mode(pulse_mode), .asleep(asleep),
      .first_result_ready(first_ready));
   tsp_smb_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] flags_exp(input logic [31:0] c);
      return {24'h0, c[4], 1'b0, c[5], c[6], 4'h0};
   endfunction
   function automatic int duty_exp(input int p);
      return p - p / 8;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      if (num_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] d,
                     output logic [31:0] rd);
      int k;
      k = 0;
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++k < 50);
      if (k >= 50) num_errors++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 300000) begin
         num_errors++;
         final_report;
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      av(0, 4'h5, 0, q);
      check(q, 32'h0000_005A);
      av(0, 4'h7, 0, q);
      check(q, 32'h0000_2000);
      av(1, 4'hC, rnd(), q);
      av(0, 4'hC, 0, q);
      check(q, 32'h0);
      // Flags read, stopped after the first byte
      r = rnd();
      r = {25'h0, 1'b1, r[1:0], 4'h0};
      av(1, 4'h0, r, q);
      m.start();
      m.xbyte(8'hB4, 1'b1, b, a);
      check(32'(a), 32'h1);
      m.xbyte(8'hF0, 1'b1, b, a);
      m.xbyte(8'hFF, 1'b1, b, a);
      check(32'(b), flags_exp(r));
      m.stop();
      // Erase then write one memory word through the broadcast address
      w = rnd();
      for (int k = 0; k < 2; k++) begin
         m.start();
         m.xbyte(8'h00, 1'b1, b, a);
         check(32'(a), 32'h1);
         m.xbyte(8'h2E, 1'b1, b, a);
         m.xbyte(k ? w[7:0] : 8'h00, 1'b1, b, a);
         m.xbyte(k ? w[15:8] : 8'h00, 1'b1, b, a);
         m.xbyte(m.pec, 1'b1, b, a);
         check(32'(a), 32'h1);
         m.stop();
      end
      av(0, 4'h6, 0, q);
      check(q, {11'h0, 5'h0E, w});
      // Sleep, wake into push-pull pulse output with the fatal error band
      av(1, 4'h7, 32'h0000_0400, q);
      av(1, 4'h0, 32'h0000_0063, q);
      m.start();
      m.xbyte(8'hB4, 1'b1, b, a);
      m.xbyte(8'hFF, 1'b1, b, a);
      m.stop();
      av(0, 4'h1, 0, q);
      check(32'(q[2]), 32'h1);
      m.wake(600);
      check(32'(pulse_mode), 32'h1);
      for (n = 0; n < 2000 && first_ready !== 1'b1; n++) @(posedge ref_clk);
      check(32'(first_ready), 32'h1);
      while (sda !== 1'b0) @(posedge ref_clk);
      while (sda !== 1'b1) @(posedge ref_clk);
      for (n = 0; sda === 1'b1 && n < 5000; n++) @(posedge ref_clk);
      check(32'(n >= duty_exp(1024) - 1 && n <= duty_exp(1024) + 1), 32'h1);
      check(32'(sda_oe), 32'h1);
      m.hold_low(700);
      check(32'(pulse_mode), 32'h0);
      // Clock stuck low while the block sends, then bits with no start
      m.start();
      m.xbyte(8'hB4, 1'b1, b, a);
      m.xbyte(8'hF0, 1'b1, b, a);
      m.wt(100);
      check(32'(sda_oe), 32'h1);
      m.hold_low(2600);
      check(32'(sda_oe), 32'h0);
      m.xbyte(8'hB4, 1'b1, b, a);
      check(32'(a), 32'h0);
      m.stop();
      m.start();
      m.xbyte(8'h66, 1'b1, b, a);
      check(32'(a), 32'h0);
      m.stop();
      final_report;
   end
endmodule
`default_nettype wire
